/* src/dss_pkg.sv */
// shared constants and carrier types for the drive status block
package dss_pkg;
   // ----------------------------------------
   // clock and timing
   // ----------------------------------------
   localparam int CLK_KHZ = 25000;
   localparam int SPINUP_MS = 480;
   localparam int SPINUP_CYC = CLK_KHZ * SPINUP_MS;
   localparam int READY_LIMIT_MS = 500;
   localparam int READY_LIMIT_CYC = CLK_KHZ * READY_LIMIT_MS;
   localparam int READY_DROP_NS = 300000;
   localparam int READY_DROP_CYC = READY_DROP_NS / 40;
   localparam int PWR_RST_US = 350;
   localparam int PWR_RST_CYC = (CLK_KHZ * PWR_RST_US) / 1000;
   localparam int SELECT_VALID_NS = 500;
   localparam int SELECT_VALID_CYC = SELECT_VALID_NS / 40;
   localparam int CNT_W = 24;
   localparam int SYNC_W = 10;
   // ----------------------------------------
   // reset values
   // ----------------------------------------
   localparam logic SWAPPED_RST = 1'b1;
   // host lines idle high, sensors and supply flags low
   localparam logic [SYNC_W-1:0] SYNC_RST = 10'h0F0;
   // ----------------------------------------
   // types
   // ----------------------------------------
   typedef struct packed {
      logic present;
      logic inhibit_open;
      logic hd_hole;
      logic rev_sensor;
   } dss_sense_t;
   typedef struct packed {
      logic unit_select_n;
      logic spindle_request_n;
      logic head_step_pulse_n;
      logic write_gate_n;
   } dss_host_t;
   typedef enum logic [1:0] {
      SP_IDLE = 2'b00,
      SP_SPINUP = 2'b01,
      SP_WAIT_MARK = 2'b10,
      SP_READY = 2'b11
   } dss_spin_t;
endpackage

/* src/dss_drive_status.sv */
// drive status, protection, ready and spindle supervision logic
`timescale 1ns/100ps
// Summary of operation
// - media_locked shown while inhibit opening uncovered; writing refused then.
// - media_swapped set at power-up and whenever the medium is removed.
// - media_swapped clears on a selected step once a medium is present.
// - ready needs power, medium, 480 ms spindle request and a revolution mark.
// - ready rises within 500 ms of spindle start.
// - ready drops within 0.3 ms of spindle request going away.
// - density mode follows the high-density opening of the medium.
// - read pulses within 350 ns or 700 ns of nominal position.
// - writing blocked while supply is low during power transitions.
// - no writing unless the write gate is asserted.
// - internal power-up reset finishes within 350 us.
// - stand-by while spindle stopped and head idle.
// - stand-by never delays or restricts a host command.
// - front indicator lit exactly while selected and ready.
// - spindle runs on request, never without a medium.
// - interface signals are active low unless stated otherwise.
// - outputs valid within 0.5 us of unit select.
// - one revolution mark pulse per turn of the medium; the code gives REVOLUTION_MARK_N only while selected and ready.
module dss_drive_status
   import dss_pkg::*;
#(
   parameter int SPINUP_CYCLES = SPINUP_CYC,
   parameter int PWR_RST_CYCLES = PWR_RST_CYC
) (
   input wire logic CORE_CLK,
   input wire logic SYS_RST,
   input wire dss_host_t HOST_IN,
   input wire dss_sense_t MEDIA_SENSE,
   input wire logic SUPPLY_LOW,
   input wire logic HEAD_BUSY,
   output logic MEDIA_LOCKED_N,
   output logic MEDIA_SWAPPED_N,
   output logic READY_N,
   output logic REVOLUTION_MARK_N,
   output logic DENSITY_INDICATOR,
   output logic HIGH_DENSITY_MODE,
   output logic WRITE_ENABLE,
   output logic SPINDLE_RUN,
   output logic FRONT_INDICATOR,
   output logic STANDBY
);
   if (SPINUP_CYCLES < 1 || SPINUP_CYCLES >= (1 << CNT_W)) begin : g_bad_spinup
      $error("SPINUP_CYCLES out of range");
   end
   if (PWR_RST_CYCLES < 1 || PWR_RST_CYCLES >= (1 << CNT_W)) begin : g_bad_init
      $error("PWR_RST_CYCLES out of range");
   end
   // ----------------------------------------
   // input synchronisers
   // ----------------------------------------
   logic [SYNC_W-1:0] meta_r;
   logic [SYNC_W-1:0] sync_r;
   always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         meta_r <= SYNC_RST;
         sync_r <= SYNC_RST;
      end else begin
         meta_r <= {SUPPLY_LOW, HEAD_BUSY, HOST_IN, MEDIA_SENSE};
         sync_r <= meta_r;
      end
   end
   logic supply_low;
   logic head_busy;
   dss_host_t host;
   dss_sense_t sense;
   assign {supply_low, head_busy, host, sense} = sync_r;
   // active-low interface decoded once here
   logic selected;
   logic spin_req;
   logic step_lvl;
   logic gate;
   assign selected = ~host.unit_select_n;
   assign spin_req = ~host.spindle_request_n;
   assign step_lvl = ~host.head_step_pulse_n;
   assign gate = ~host.write_gate_n;
   // ----------------------------------------
   // state
   // ----------------------------------------
   dss_spin_t spin_r, spin_nxt;
   logic [CNT_W-1:0] cnt_r, cnt_nxt;
   logic [CNT_W-1:0] init_r, init_nxt;
   logic init_done_r, init_done_nxt;
   logic swapped_r, swapped_nxt;
   logic step_d_r, rev_d_r;
   logic mark_seen_r, mark_seen_nxt;
   logic ready_int;
   logic spin_run;
   logic step_edge;
   logic rev_edge;
   logic write_ok;
   logic locked_nxt, swapped_o_nxt, ready_o_nxt, mark_o_nxt;
   assign step_edge = step_lvl & ~step_d_r;
   assign rev_edge = sense.rev_sensor & ~rev_d_r;
   assign spin_run = spin_req & sense.present;
   assign ready_int = (spin_nxt == SP_READY);
   always_comb begin
      init_nxt = init_r;
      init_done_nxt = init_done_r;
      // power-up reset window; ends after PWR_RST_CYCLES cycles, right at the 350 us limit
      if (!init_done_r) begin
         if (init_r == CNT_W'(PWR_RST_CYCLES - 1)) begin
            init_done_nxt = 1'b1;
         end else begin
            init_nxt = init_r + 1'b1;
         end
      end
      // media swap latch: removal set wins, a selected step clears, otherwise holds
      swapped_nxt = swapped_r;
      if (!sense.present) begin
         swapped_nxt = 1'b1;
      end else if (selected && step_edge) begin
         swapped_nxt = 1'b0;
      end
      // spindle / ready sequencing
      spin_nxt = spin_r;
      cnt_nxt = cnt_r;
      if (!spin_run || !init_done_r) begin
         spin_nxt = SP_IDLE;
         cnt_nxt = '0;
      end else begin
         case (spin_r)
            SP_IDLE: begin
               spin_nxt = SP_SPINUP;
               cnt_nxt = '0;
            end
            SP_SPINUP: begin
               if (cnt_r == CNT_W'(SPINUP_CYCLES - 1)) begin
                  // a mark seen during spin-up lets ready come at once
                  if (mark_seen_r || rev_edge) begin
                     spin_nxt = SP_READY;
                  end else begin
                     spin_nxt = SP_WAIT_MARK;
                  end
               end else begin
                  cnt_nxt = cnt_r + 1'b1;
               end
            end
            SP_WAIT_MARK: begin
               if (rev_edge) begin
                  spin_nxt = SP_READY;
               end
            end
            SP_READY: spin_nxt = SP_READY;
            default: spin_nxt = SP_IDLE;
         endcase
      end
      write_ok = gate & selected & ~sense.inhibit_open & ~supply_low & init_done_r;
      // outputs only meaningful while selected
      locked_nxt = ~(selected & sense.present & sense.inhibit_open);
      swapped_o_nxt = ~(selected & swapped_nxt);
      ready_o_nxt = ~(selected & ready_int);
      mark_o_nxt = ~(selected & ready_int & rev_edge);
   end
   // mark seen during spin-up kept in a separate flag
   always_comb begin
      mark_seen_nxt = mark_seen_r;
      if (spin_r == SP_IDLE || !spin_run) begin
         mark_seen_nxt = 1'b0;
      end else if (rev_edge) begin
         mark_seen_nxt = 1'b1;
      end
   end
   logic ready_r;
   always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         spin_r <= SP_IDLE;
         cnt_r <= '0;
         init_r <= '0;
         init_done_r <= 1'b0;
         swapped_r <= SWAPPED_RST;
         step_d_r <= 1'b0;
         rev_d_r <= 1'b0;
         mark_seen_r <= 1'b0;
         ready_r <= 1'b0;
         MEDIA_LOCKED_N <= 1'b1;
         MEDIA_SWAPPED_N <= 1'b1;
         READY_N <= 1'b1;
         REVOLUTION_MARK_N <= 1'b1;
         DENSITY_INDICATOR <= 1'b1;
         HIGH_DENSITY_MODE <= 1'b1;
         WRITE_ENABLE <= 1'b0;
         SPINDLE_RUN <= 1'b0;
         FRONT_INDICATOR <= 1'b0;
         STANDBY <= 1'b1;
      end else begin
         spin_r <= spin_nxt;
         cnt_r <= cnt_nxt;
         init_r <= init_nxt;
         init_done_r <= init_done_nxt;
         swapped_r <= swapped_nxt;
         step_d_r <= step_lvl;
         rev_d_r <= sense.rev_sensor;
         mark_seen_r <= mark_seen_nxt;
         ready_r <= ready_int;
         MEDIA_LOCKED_N <= locked_nxt;
         MEDIA_SWAPPED_N <= swapped_o_nxt;
         READY_N <= ready_o_nxt;
         REVOLUTION_MARK_N <= mark_o_nxt;
         DENSITY_INDICATOR <= sense.hd_hole | ~sense.present;
         // read cell window downstream follows this mode
         HIGH_DENSITY_MODE <= sense.hd_hole | ~sense.present;
         WRITE_ENABLE <= write_ok;
         SPINDLE_RUN <= spin_run;
         FRONT_INDICATOR <= selected & ready_int;
         // stand-by gates only power, never the command path
         STANDBY <= ~spin_run & ~head_busy;
      end
   end
   // ----------------------------------------
   // assertions
   // ----------------------------------------
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (SYS_RST);
   sequence s_removed;
      !sense.present;
   endsequence
   sequence s_sel_step;
      sense.present && selected && step_edge;
   endsequence
   property p_locked_blocks;
      sense.inhibit_open |=> !WRITE_ENABLE;
   endproperty
   a_locked_blocks: assert property (p_locked_blocks) else $error("write while locked");
   property p_swap_set;
      s_removed ##0 selected |=> swapped_r && !MEDIA_SWAPPED_N;
   endproperty
   a_swap_set: assert property (p_swap_set) else $error("swap not set on removal");
   property p_swap_clear;
      s_sel_step |=> !swapped_r;
   endproperty
   a_swap_clear: assert property (p_swap_clear) else $error("swap not cleared by step");
   property p_swap_hold;
      (swapped_r && sense.present && !(selected && step_edge)) |=> swapped_r;
   endproperty
   a_swap_hold: assert property (p_swap_hold) else $error("swap latch lost");
   property p_ready_cause;
      ready_r |-> $past(sense.present && spin_req && init_done_r);
   endproperty
   a_ready_cause: assert property (p_ready_cause) else $error("ready without cause");
   property p_ready_mark;
      $rose(ready_r) |-> $past(mark_seen_r || rev_edge);
   endproperty
   a_ready_mark: assert property (p_ready_mark) else $error("ready without mark");
   property p_ready_drop;
      (ready_r && !spin_req) |=> ##[0:1] !ready_r ##1 READY_N;
   endproperty
   a_ready_drop: assert property (p_ready_drop) else $error("ready slow to drop");
   property p_write_gate;
      !gate |=> !WRITE_ENABLE;
   endproperty
   a_write_gate: assert property (p_write_gate) else $error("write without gate");
   property p_supply_low;
      supply_low |=> !WRITE_ENABLE;
   endproperty
   a_supply_low: assert property (p_supply_low) else $error("write at low supply");
   property p_indicator;
      (selected && ready_int) |=> FRONT_INDICATOR;
   endproperty
   a_indicator: assert property (p_indicator) else $error("indicator off");
   property p_no_media_spin;
      !sense.present |=> !SPINDLE_RUN;
   endproperty
   a_no_media_spin: assert property (p_no_media_spin) else $error("spin with no medium");
   property p_density;
      (sense.present && !sense.hd_hole) |=> !DENSITY_INDICATOR;
   endproperty
   a_density: assert property (p_density) else $error("density level wrong");
   property p_standby;
      (!spin_run && !head_busy) |=> STANDBY;
   endproperty
   a_standby: assert property (p_standby) else $error("no stand-by");
endmodule

/* sim/dss_media_model.sv */
// medium and rotation sensor model facing the drive status block
`timescale 1ns/100ps
module dss_media_model
   import dss_pkg::*;
#(
   parameter int REV_PERIOD = 20
) (
   input wire logic CORE_CLK,
   input wire logic SYS_RST,
   input wire logic SPINDLE_RUN,
   input wire logic LOAD,
   input wire logic DOUBLE,
   input wire logic PROTECT,
   input wire logic BLANK,
   output dss_sense_t MEDIA_SENSE
);
   // ----------------------------------------
   // rotation
   // ----------------------------------------
   int rev_cnt_r;
   always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         rev_cnt_r <= 0;
      end else if (!SPINDLE_RUN) begin
         rev_cnt_r <= 0;
      end else begin
         rev_cnt_r <= (rev_cnt_r == REV_PERIOD - 1) ? 0 : rev_cnt_r + 1;
      end
   end
   // ----------------------------------------
   // sensor levels
   // ----------------------------------------
   // one short sensor pulse per turn, dead while stopped or blanked
   logic rev_level;
   assign rev_level = SPINDLE_RUN && !BLANK && (rev_cnt_r < 2);
   // field order: present, inhibit opening, density hole, rotation sensor
   assign MEDIA_SENSE = {LOAD, LOAD && PROTECT, LOAD && !DOUBLE, rev_level};
endmodule

/* sim/dss_drive_status_bench.sv */
// self-checking bench for the drive status block
`timescale 1ns/100ps
module dss_drive_status_bench
   import dss_pkg::*;
;
   logic core_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic supply_low = 1'b0;
   logic head_busy = 1'b0;
   logic load = 1'b1;
   logic dbl = 1'b0;
   logic prot = 1'b0;
   logic blank = 1'b0;
   // selected, spindle off, step idle, gate on
   dss_host_t host = 4'h6;
   dss_sense_t sense;
   logic locked_n, swapped_n, ready_n, mark_n, dens, hd_mode, wr_en, spin, front, stby;
   int err_total = 0;
   int checked = 0;
   int cyc = 0;
   int n;
   // ----------------------------------------
   // clock, instances, timeout
   // ----------------------------------------
   always #20 core_clk = ~core_clk;
   dss_drive_status #(.SPINUP_CYCLES(50), .PWR_RST_CYCLES(10)) i_dut (
      .CORE_CLK(core_clk), .SYS_RST(sys_rst), .HOST_IN(host), .MEDIA_SENSE(sense),
      .SUPPLY_LOW(supply_low), .HEAD_BUSY(head_busy), .MEDIA_LOCKED_N(locked_n),
      .MEDIA_SWAPPED_N(swapped_n), .READY_N(ready_n), .REVOLUTION_MARK_N(mark_n),
      .DENSITY_INDICATOR(dens), .HIGH_DENSITY_MODE(hd_mode), .WRITE_ENABLE(wr_en),
      .SPINDLE_RUN(spin), .FRONT_INDICATOR(front), .STANDBY(stby));
   dss_media_model #(.REV_PERIOD(20)) i_media (
      .CORE_CLK(core_clk), .SYS_RST(sys_rst), .SPINDLE_RUN(spin), .LOAD(load),
      .DOUBLE(dbl), .PROTECT(prot), .BLANK(blank), .MEDIA_SENSE(sense));
   // run should need well under 1000 cycles
   always @(posedge core_clk) begin
      cyc = cyc + 1;
      if (cyc == 3000) begin
         err_total = err_total + 1;
         conclude();
      end
   end
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task conclude();
      $display("checks %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // ends 1 ns past the edge so registered outputs have landed
   task step(input int k);
      repeat (k) @(posedge core_clk);
      #1;
   endtask
   task chk(input string what, input logic exp, input logic got);
      checked = checked + 1;
      if (got !== exp) begin
         err_total = err_total + 1;
         $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
      end
   endtask
   task pulse_step();
      @(posedge core_clk) host.head_step_pulse_n <= 1'b0;
      step(3);
      @(posedge core_clk) host.head_step_pulse_n <= 1'b1;
      step(5);
   endtask
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      repeat (10) @(posedge core_clk);
      sys_rst <= 1'b0;
      step(4);
      chk("write_enable in init", 1'b0, wr_en);
      step(14);
      chk("write_enable gated", 1'b1, wr_en);
      chk("swapped at power-up", 1'b0, swapped_n);
      chk("density high", 1'b1, dens);
      chk("hd mode", 1'b1, hd_mode);
      @(posedge core_clk) supply_low <= 1'b1;
      step(5);
      chk("write_enable low supply", 1'b0, wr_en);
      @(posedge core_clk) supply_low <= 1'b0;
      prot <= 1'b1;
      step(5);
      chk("locked", 1'b0, locked_n);
      chk("write_enable locked", 1'b0, wr_en);
      @(posedge core_clk) prot <= 1'b0;
      host.write_gate_n <= 1'b1;
      step(5);
      chk("write_enable no gate", 1'b0, wr_en);
      @(posedge core_clk) dbl <= 1'b1;
      step(5);
      chk("density double", 1'b0, dens);
      chk("normal mode", 1'b0, hd_mode);
      @(posedge core_clk) host.unit_select_n <= 1'b1;
      pulse_step();
      @(posedge core_clk) host.unit_select_n <= 1'b0;
      step(5);
      chk("swapped after unselected step", 1'b0, swapped_n);
      pulse_step();
      chk("swapped cleared in standby", 1'b1, swapped_n);
      @(posedge core_clk) load <= 1'b0;
      step(5);
      chk("swapped on removal", 1'b0, swapped_n);
      chk("density no medium", 1'b1, dens);
      @(posedge core_clk) host.spindle_request_n <= 1'b0;
      step(5);
      chk("spindle empty", 1'b0, spin);
      chk("standby stopped", 1'b1, stby);
      @(posedge core_clk) load <= 1'b1;
      dbl <= 1'b0;
      step(5);
      chk("spindle runs", 1'b1, spin);
      chk("standby spinning", 1'b0, stby);
      chk("swapped kept", 1'b0, swapped_n);
      pulse_step();
      chk("swapped cleared", 1'b1, swapped_n);
      step(30);
      chk("ready early", 1'b1, ready_n);
      n = 0;
      while (ready_n !== 1'b0 && n < 60) begin
         step(1);
         n = n + 1;
      end
      chk("ready in time", 1'b1, n < 60);
      chk("front lit", 1'b1, front);
      n = 0;
      repeat (60) begin
         step(1);
         if (mark_n === 1'b0) n = n + 1;
      end
      chk("three marks in three turns", 1'b1, n == 3);
      @(posedge core_clk) host.unit_select_n <= 1'b1;
      step(5);
      chk("front unselected", 1'b0, front);
      chk("ready unselected", 1'b1, ready_n);
      @(posedge core_clk) host.unit_select_n <= 1'b0;
      step(4);
      chk("ready valid after select", 1'b0, ready_n);
      @(posedge core_clk) host.spindle_request_n <= 1'b1;
      step(4);
      chk("ready dropped", 1'b1, ready_n);
      chk("spindle off", 1'b0, spin);
      @(posedge core_clk) head_busy <= 1'b1;
      step(5);
      chk("standby head busy", 1'b0, stby);
      @(posedge core_clk) head_busy <= 1'b0;
      step(5);
      chk("standby idle", 1'b1, stby);
      // spin-up with the mark hidden: ready must wait for the first mark
      @(posedge core_clk) blank <= 1'b1;
      host.spindle_request_n <= 1'b0;
      step(70);
      chk("ready waits for mark", 1'b1, ready_n);
      @(posedge core_clk) blank <= 1'b0;
      n = 0;
      while (ready_n !== 1'b0 && n < 40) begin
         step(1);
         n = n + 1;
      end
      chk("ready on first mark", 1'b1, n < 40);
      conclude();
   end
endmodule
